// ---- design/pei_pkg.sv ----
package pei_pkg;

   localparam int          CH_COUNT      = 4;
   localparam int          PAIR_COUNT    = CH_COUNT / 2;
   localparam int          REG_W         = 8;
   localparam int          CODE_W        = 8;

   // command codes
   localparam logic [7:0]  CMD_IRQ_SUM   = 8'h00;
   localparam logic [7:0]  CMD_IRQ_MASK  = 8'h01;
   localparam logic [7:0]  CMD_PWR_VIEW  = 8'h02;
   localparam logic [7:0]  CMD_PWR_CLEAR = 8'h03;

   // power event register layout
   localparam int          PWR_ENA_LSB   = 0;
   localparam int          PWR_GOOD_LSB  = 4;

   // interrupt summary / mask bit positions
   localparam int          SUM_ENA_CHG   = 0;
   localparam int          SUM_GOOD_CHG  = 1;
   localparam int          SUM_OTHER_LSB = 2;
   localparam int          OTHER_W       = 6;

   localparam logic [7:0]  MASK_RESET    = 8'h80;
   localparam logic [7:0]  PWR_RESET     = 8'h00;
   localparam logic [7:0]  RD_IDLE       = 8'h00;

endpackage

// ---- design/pei_pair_merge.sv ----
`timescale 1ns/1ps
module pei_pair_merge
   import pei_pkg::*;
#(
   parameter int CH = pei_pkg::CH_COUNT
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic [CH-1:0]   goodChange,
   input  wire logic [CH/2-1:0] fourPair,
   input  wire logic [CH/2-1:0] singleSig,
   output logic      [CH-1:0]   goodSet
);
   import pei_pkg::*;

   logic [CH-1:0] pend_q;
   logic [CH-1:0] pend_d;

   initial begin
      if (CH % 2 != 0) $error("pei_pair_merge: channel count must be even");
   end

   always_comb begin
      logic [1:0] acc;
      acc     = 2'b00;
      pend_d  = '0;
      goodSet = '0;
      for (int p = 0; p < CH / 2; p++) begin
         if (fourPair[p] && singleSig[p]) begin
            // hold the first channel until its partner changes too
            acc = pend_q[2*p +: 2] | goodChange[2*p +: 2];
            if (acc == 2'b11) begin
               goodSet[2*p +: 2] = 2'b11;
            end else begin
               pend_d[2*p +: 2] = acc;
            end
         end else begin
            goodSet[2*p +: 2] = goodChange[2*p +: 2];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= '0;
      end else begin
         pend_q <= pend_d;
      end
   end

endmodule

// ---- design/pei_power_event_irq.sv ----
`timescale 1ns/1ps
module pei_power_event_irq
   import pei_pkg::*;
#(
   parameter int CH = pei_pkg::CH_COUNT
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic [pei_pkg::CODE_W-1:0] cmdCode,
   input  wire logic                     cmdWrite,
   input  wire logic                     cmdRead,
   input  wire logic [pei_pkg::REG_W-1:0]  cmdWrData,
   output logic      [pei_pkg::REG_W-1:0]  cmdRdData,
   output logic                          cmdRdValid,
   input  wire logic [CH-1:0]            chanEnable,
   input  wire logic [CH-1:0]            chanGood,
   input  wire logic [CH/2-1:0]          portFourPair,
   input  wire logic [CH/2-1:0]          portSingleSig,
   input  wire logic [pei_pkg::OTHER_W-1:0] otherSummary,
   input  wire logic                     globalIrqEnable,
   input  wire logic                     clearAllEvents,
   output logic                          irq_n
);
   import pei_pkg::*;

   // the register layout is fixed at four channels, two flags each
   initial begin
      if (CH != CH_COUNT) begin
         $error("pei_power_event_irq: register holds four channels");
      end
      if (REG_W != 2 * CH_COUNT) begin
         $error("pei_power_event_irq: flags need two bits per channel");
      end
      if (PWR_GOOD_LSB != PWR_ENA_LSB + CH_COUNT) begin
         $error("pei_power_event_irq: good flags must sit above enable");
      end
      if (SUM_OTHER_LSB + OTHER_W != REG_W) begin
         $error("pei_power_event_irq: summary width mismatch");
      end
   end

   logic [REG_W-1:0] mask_q,    mask_d;
   logic [REG_W-1:0] pwrFlags_q, pwrFlags_d;
   logic [CH-1:0]    enaPrev_q, enaPrev_d;
   logic [CH-1:0]    goodPrev_q, goodPrev_d;
   logic [REG_W-1:0] rdData_q,  rdData_d;
   logic             rdValid_q, rdValid_d;
   logic             irq_n_q,   irq_n_d;

   logic [CH-1:0]    enaChange;
   logic [CH-1:0]    goodChange;
   logic [CH-1:0]    goodSet;
   logic [REG_W-1:0] summary;
   logic [REG_W-1:0] flagSet;
   logic             clearNow;

   // status arrives from logic on this clock, so no synchroniser
   assign enaChange  = enaPrev_q ^ chanEnable;
   assign goodChange = goodPrev_q ^ chanGood;

   pei_pair_merge #(
      .CH         (CH)
   ) u_pair_merge (
      .clk        (clk),
      .rst_n      (rst_n),
      .goodChange (goodChange),
      .fourPair   (portFourPair),
      .singleSig  (portSingleSig),
      .goodSet    (goodSet)
   );

   function automatic logic [REG_W-1:0] build_summary(
      input logic [REG_W-1:0]   flags,
      input logic [OTHER_W-1:0] others
   );
      logic [REG_W-1:0] s;
      s = '0;
      s[SUM_ENA_CHG]  = |flags[PWR_ENA_LSB +: CH_COUNT];
      s[SUM_GOOD_CHG] = |flags[PWR_GOOD_LSB +: CH_COUNT];
      s[SUM_OTHER_LSB +: OTHER_W] = others;
      return s;
   endfunction

   // summary ignores the mask entirely
   assign summary = build_summary(pwrFlags_q, otherSummary);

   always_comb begin
      flagSet = '0;
      flagSet[PWR_ENA_LSB +: CH]  = enaChange;
      flagSet[PWR_GOOD_LSB +: CH] = goodSet;
   end

   function automatic logic hits(
      input logic              strobe,
      input logic [CODE_W-1:0] code,
      input logic [CODE_W-1:0] want
   );
      return strobe && (code == want);
   endfunction

   // host writes reach only the mask byte; other codes are ignored
   always_comb begin
      mask_d = mask_q;
      if (hits(cmdWrite, cmdCode, CMD_IRQ_MASK)) begin
         mask_d = cmdWrData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= MASK_RESET;
      end else begin
         mask_q <= mask_d;
      end
   end

   // history resets to 0: a status high at release counts as a change
   always_comb begin
      enaPrev_d  = chanEnable;
      goodPrev_d = chanGood;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enaPrev_q  <= '0;
         goodPrev_q <= '0;
      end else begin
         enaPrev_q  <= enaPrev_d;
         goodPrev_q <= goodPrev_d;
      end
   end

   assign clearNow = hits(cmdRead, cmdCode, CMD_PWR_CLEAR) || clearAllEvents;

   // clear first, then new events on top: a set in the clearing
   // cycle survives rather than being lost
   always_comb begin
      pwrFlags_d = pwrFlags_q;
      if (clearNow) begin
         pwrFlags_d = PWR_RESET;
      end
      pwrFlags_d = pwrFlags_d | flagSet;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwrFlags_q <= PWR_RESET;
      end else begin
         pwrFlags_q <= pwrFlags_d;
      end
   end

   // unmapped codes still pulse valid, with idle data
   always_comb begin
      rdData_d  = RD_IDLE;
      rdValid_d = 1'b0;
      if (cmdRead) begin
         rdValid_d = 1'b1;
         case (cmdCode)
            CMD_IRQ_SUM:   rdData_d = summary;
            CMD_IRQ_MASK:  rdData_d = mask_q;
            CMD_PWR_VIEW:  rdData_d = pwrFlags_q;
            CMD_PWR_CLEAR: rdData_d = pwrFlags_q;
            default:       rdData_d = RD_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_q  <= RD_IDLE;
         rdValid_q <= 1'b0;
      end else begin
         rdData_q  <= rdData_d;
         rdValid_q <= rdValid_d;
      end
   end

   always_comb begin
      logic [REG_W-1:0] nextSum;
      nextSum = build_summary(pwrFlags_d, otherSummary);
      // gate on next state so a clear-on-read releases in the same edge
      irq_n_d = ~(globalIrqEnable && |(nextSum & mask_d));
   end

   // pin held released through reset, never glitching low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= irq_n_d;
      end
   end

   assign cmdRdData  = rdData_q;
   assign cmdRdValid = rdValid_q;
   assign irq_n      = irq_n_q;

endmodule

// ---- testbench/pei_irq_monitor.sv ----
`timescale 1ns/1ps
module pei_irq_monitor
   import pei_pkg::*;
#(parameter int CH = CH_COUNT) (
   input wire logic          clk,
   input wire logic          rst_n,
   input wire logic [7:0]    cmdCode,
   input wire logic          cmdWrite,
   input wire logic          cmdRead,
   input wire logic [7:0]    cmdWrData,
   input wire logic [7:0]    cmdRdData,
   input wire logic          cmdRdValid,
   input wire logic [CH-1:0] chanEnable,
   input wire logic [CH-1:0] chanGood,
   input wire logic [5:0]    otherSummary,
   input wire logic          globalIrqEnable,
   input wire logic          clearAllEvents,
   input wire logic          irq_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [2*CH-1:0] prevQ;
   // zeroed like the block's status history, so first-edge events count
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         prevQ <= '0;
      else
         prevQ <= {chanGood, chanEnable};
   wire q = prevQ == {chanGood, chanEnable};
   wire rd2 = cmdRead && cmdCode == CMD_PWR_VIEW && !clearAllEvents;
   wire rd3 = cmdRead && cmdCode == CMD_PWR_CLEAR;
   rd_pulse_a: assert property (cmdRead |=> cmdRdValid)
      else $error("read not answered");
   rd_idle_a: assert property (
      !cmdRead |=> !cmdRdValid && cmdRdData == 8'h00) else $error("stray");
   unmapped_zero_a: assert property (
      cmdRead && cmdCode > CMD_PWR_CLEAR |=> cmdRdData == 8'h00)
      else $error("unmapped read not zero");
   gate_off_a: assert property (!globalIrqEnable |=> irq_n)
      else $error("irq without enable");
   mask_back_a: assert property (
      cmdWrite && cmdCode == CMD_IRQ_MASK ##1
      cmdRead && cmdCode == CMD_IRQ_MASK |=> cmdRdData == $past(cmdWrData, 2))
      else $error("mask readback");
   view_same_a: assert property (
      rd2 && q ##1 rd2 && q |=> cmdRdData == $past(cmdRdData))
      else $error("view read changed flags");
   clear_zero_a: assert property (
      rd3 && q ##1 rd3 && q |=> cmdRdData == 8'h00) else $error("not cleared");
   release_a: assert property (
      (rd3 || clearAllEvents) && q && otherSummary == 6'h00 |=> irq_n)
      else $error("irq not released");
   cover property (rd3 ##1 rd3);
   cover property (!irq_n);
   cover property (clearAllEvents);
endmodule

bind pei_power_event_irq pei_irq_monitor #(.CH(CH)) mon (.*);

// ---- testbench/pei_host_model.sv ----
`timescale 1ns/1ps
module pei_host_model (
   input  wire logic [7:0] cmdRdData,
   input  wire logic       clk,
   output logic      [7:0] cmdCode,
   output logic      [7:0] cmdWrData,
   output logic            cmdWrite,
   output logic            cmdRead
);
   initial {cmdCode, cmdWrData, cmdWrite, cmdRead} = '0;
   // optional write, then two reads back to back at the same code;
   // the second read shows what a clear-on-read left behind
   task automatic acc(input logic w, input logic [7:0] c, d,
                      output logic [7:0] d1, d2);
      @(negedge clk);
      cmdCode = c;
      cmdWrData = d;
      if (w) begin
         cmdWrite = 1'b1;
         @(negedge clk);
         cmdWrite = 1'b0;
      end
      cmdRead = 1'b1;
      @(negedge clk);
      d1 = cmdRdData;
      @(negedge clk);
      d2 = cmdRdData;
      cmdRead = 1'b0;
   endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
   logic       clk = 1'b0, rst_n = 1'b0, cmdWrite, cmdRead, cmdRdValid, irq_n;
   logic [7:0] cmdCode, cmdWrData, cmdRdData, a, b;
   logic [3:0] chanEnable = '0, chanGood = '0;
   logic [1:0] portFourPair = '0, portSingleSig = '0;
   logic [5:0] otherSummary = '0;
   logic       globalIrqEnable = 1'b0, clearAllEvents = 1'b0;
   int         n_mismatch = 0, checks_done = 0;
   always #10 clk = ~clk;
   pei_host_model host (.*);
   pei_power_event_irq dut (.*);
   task automatic chk(input logic [7:0] s, e);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic op(input logic w, input logic [7:0] c, d, e1, e2);
      host.acc(w, c, d, a, b);
      chk(a, e1);
      chk(b, e2);
   endtask
   task automatic finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      op(1'b0, 8'h01, 8'h00, 8'h80, 8'h80);
      op(1'b0, 8'h02, 8'h00, 8'h00, 8'h00);
      globalIrqEnable = 1'b1;
      otherSummary = 6'h20;
      op(1'b0, 8'h05, 8'h00, 8'h00, 8'h00);
      chk(irq_n, 8'h00);
      op(1'b1, 8'h01, 8'h01, 8'h01, 8'h01);
      chk(irq_n, 8'h01);
      chanEnable[2] = 1'b1;
      op(1'b0, 8'h00, 8'h00, 8'h81, 8'h81);
      chk(irq_n, 8'h00);
      otherSummary = '0;
      op(1'b0, 8'h02, 8'h00, 8'h04, 8'h04);
      op(1'b0, 8'h03, 8'h00, 8'h04, 8'h00);
      chk(irq_n, 8'h01);
      globalIrqEnable = 1'b0;
      chanEnable[2] = 1'b0;
      op(1'b0, 8'h02, 8'h00, 8'h04, 8'h04);
      chk(irq_n, 8'h01);
      clearAllEvents = 1'b1;
      @(negedge clk);
      clearAllEvents = 1'b0;
      op(1'b0, 8'h00, 8'h00, 8'h00, 8'h00);
      globalIrqEnable = 1'b1;
      portFourPair = 2'b01;
      portSingleSig = 2'b01;
      op(1'b1, 8'h01, 8'h02, 8'h02, 8'h02);
      chanGood[0] = 1'b1;
      op(1'b0, 8'h02, 8'h00, 8'h00, 8'h00);
      chanGood[1] = 1'b1;
      op(1'b0, 8'h00, 8'h00, 8'h02, 8'h02);
      chk(irq_n, 8'h00);
      op(1'b0, 8'h03, 8'h00, 8'h30, 8'h00);
      portSingleSig = 2'b00;
      chanGood[1] = 1'b0;
      op(1'b0, 8'h03, 8'h00, 8'h20, 8'h00);
      finish_test;
   end
   initial begin
      #100000;
      n_mismatch++;
      finish_test;
   end
endmodule
